/* File: shared/irq_map_pkg.sv */
// constants and source map for the interrupt vector mapper
package irq_map_pkg;
	localparam int NUM_REQ = 64;
	localparam int LAST_REQ = 57;
	localparam int NUM_VEC = 46;
	localparam int VEC_W = 6;
	localparam int REQ_W = 6;
	localparam int PRI_W = 3;
	localparam int SUB_W = 2;
	localparam int WORD_W = 32;
	localparam int PRI_WORDS = 12;
	localparam int VEC_PER_WORD = 4;
	localparam int SLOT_STRIDE = 8;
	localparam int PRI_LSB = 2;
	localparam int SUB_LSB = 0;
	localparam int HIGH_BASE = 32;
	localparam logic [VEC_W-1:0] NO_VEC = 6'h3f;
	localparam logic [REQ_W-1:0] SPI1_FIRST = 6'h17;
	localparam logic [REQ_W-1:0] FLASH_REQ = 6'h38;
	localparam logic [REQ_W-1:0] USB_REQ = 6'h39;
	localparam logic [VEC_W-1:0] SPI1_VEC = 6'h17;
	localparam logic [VEC_W-1:0] UART1_VEC = 6'h18;
	localparam logic [VEC_W-1:0] I2C1_VEC = 6'h19;
	localparam logic [VEC_W-1:0] SPI2_VEC = 6'h1f;
	localparam logic [VEC_W-1:0] UART2_VEC = 6'h20;
	localparam logic [VEC_W-1:0] I2C2_VEC = 6'h21;
	localparam logic [VEC_W-1:0] FLASH_VEC = 6'h2c;
	localparam logic [VEC_W-1:0] USB_VEC = 6'h2d;
	localparam logic [REQ_W-1:0] GROUP_OFS = 6'h03;

	// request to vector; NO_VEC for unassigned requests
	function automatic logic [VEC_W-1:0] vec_of(input logic [REQ_W-1:0] r);
		logic [VEC_W-1:0] v;
		v = NO_VEC;
		if (r <= 6'h16)
			v = r;
		else if (r <= 6'h19)
			v = SPI1_VEC;
		else if (r <= 6'h1c)
			v = UART1_VEC;
		else if (r <= 6'h1f)
			v = I2C1_VEC;
		else if (r <= 6'h24)
			v = r - GROUP_OFS - GROUP_OFS;
		else if (r <= 6'h27)
			v = SPI2_VEC;
		else if (r <= 6'h2a)
			v = UART2_VEC;
		else if (r <= 6'h2d)
			v = I2C2_VEC;
		else if (r <= 6'h33)
			v = r - 6'h0c;
		else if (r == FLASH_REQ)
			v = FLASH_VEC;
		else if (r == USB_REQ)
			v = USB_VEC;
		return v;
	endfunction
endpackage

/* File: hw/vec_select.sv */
// finds the winning vector among pending requests
`timescale 1ns/1ps
module vec_select #(
	parameter int NREQ = irq_map_pkg::NUM_REQ
) (
	input wire logic [NREQ-1:0] pend,
	input wire logic [irq_map_pkg::PRI_WORDS*irq_map_pkg::WORD_W-1:0] prio,
	output logic found,
	output logic [irq_map_pkg::VEC_W-1:0] vec,
	output logic [irq_map_pkg::PRI_W-1:0] level
);
	always_comb begin
		logic [irq_map_pkg::PRI_W+irq_map_pkg::SUB_W-1:0] best, key;
		logic [irq_map_pkg::VEC_W-1:0] v;
		int base;
		v = '0;
		base = 0;
		key = '0;
		best = '0;
		found = 1'b0;
		vec = '0;
		level = '0;
		// lower requests first; strict greater keeps natural order on ties
		for (int r = 0; r < NREQ; r++) begin
			v = irq_map_pkg::vec_of(r[irq_map_pkg::REQ_W-1:0]);
			base = int'(v) * irq_map_pkg::SLOT_STRIDE;
			if (v != irq_map_pkg::NO_VEC) begin
				// priority and subpriority slots of the vector
				key = {prio[base+irq_map_pkg::PRI_LSB +: irq_map_pkg::PRI_W],
					prio[base+irq_map_pkg::SUB_LSB +: irq_map_pkg::SUB_W]};
				// zero priority never presents
				if (pend[r] && key[irq_map_pkg::SUB_W +: irq_map_pkg::PRI_W]
					!= '0 && (!found || key > best)) begin
					found = 1'b1;
					best = key;
					vec = v;
					level = key[irq_map_pkg::SUB_W +: irq_map_pkg::PRI_W];
				end
			end
		end
	end
endmodule // vec_select

/* File: hw/irq_vector_map.sv */
// interrupt source to vector mapper with flags, enables and priorities
`timescale 1ns/1ps
module irq_vector_map #(
	parameter int NREQ = irq_map_pkg::NUM_REQ
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [NREQ-1:0] src_event,
	input wire logic [NREQ-1:0] flag_clear,
	input wire logic [NREQ-1:0] flag_set,
	input wire logic [irq_map_pkg::WORD_W-1:0] enable_word_low,
	input wire logic [irq_map_pkg::WORD_W-1:0] enable_word_high,
	input wire logic [irq_map_pkg::PRI_WORDS*irq_map_pkg::WORD_W-1:0]
		vector_priority_word,
	input wire logic wait_enter,
	output logic [irq_map_pkg::WORD_W-1:0] flag_word_low,
	output logic [irq_map_pkg::WORD_W-1:0] flag_word_high,
	output logic irq_req,
	output logic [irq_map_pkg::VEC_W-1:0] irq_vector,
	output logic [irq_map_pkg::PRI_W-1:0] irq_level,
	output logic core_stalled
);
	typedef struct packed {
		logic [NREQ-1:0] flags;
		logic req;
		logic [irq_map_pkg::VEC_W-1:0] vec;
		logic [irq_map_pkg::PRI_W-1:0] level;
		logic stalled;
	} state_t;

	state_t s_q, s_d;
	logic [NREQ-1:0] mapped, pend, en_all;
	logic found;
	logic [irq_map_pkg::VEC_W-1:0] win_vec;
	logic [irq_map_pkg::PRI_W-1:0] win_level;

	// only assigned requests may hold a flag
	generate
		for (genvar r = 0; r < NREQ; r++) begin : g_map
			assign mapped[r] = irq_map_pkg::vec_of(
				(irq_map_pkg::REQ_W)'(r)) != irq_map_pkg::NO_VEC;
		end
	endgenerate

	// low word holds requests 0..31, high word 32 up
	assign en_all = {enable_word_high, enable_word_low};
	assign pend = s_q.flags & en_all & mapped;

	vec_select #(.NREQ(NREQ)) u_sel (
		.pend(pend),
		.prio(vector_priority_word),
		.found(found),
		.vec(win_vec),
		.level(win_level)
	);

	always_comb begin
		s_d = s_q;
		// event beats a clear in the same cycle
		s_d.flags = ((s_q.flags & ~flag_clear) | src_event | flag_set) & mapped;
		s_d.req = found;
		s_d.vec = found ? win_vec : '0;
		s_d.level = found ? win_level : '0;
		// wait stalls until a request is presented
		if (found)
			s_d.stalled = 1'b0;
		else if (wait_enter)
			s_d.stalled = 1'b1;
		if (!rstn)
			s_d = '0;
	end

	always_ff @(posedge clock) begin
		s_q <= s_d;
	end

	assign flag_word_low = s_q.flags[irq_map_pkg::WORD_W-1:0];
	assign flag_word_high = s_q.flags[irq_map_pkg::HIGH_BASE +:
		irq_map_pkg::WORD_W];
	assign irq_req = s_q.req;
	assign irq_vector = s_q.vec;
	assign irq_level = s_q.level;
	assign core_stalled = s_q.stalled;

	// checks
	property p_flag_sticky;
		@(posedge clock) disable iff (!rstn)
		(s_q.flags[0] && !flag_clear[0]) |=> s_q.flags[0];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky)
		else $error("flag dropped without clear");

	property p_set_wins;
		@(posedge clock) disable iff (!rstn)
		(src_event[5] && flag_clear[5]) |=> flag_word_low[5];
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("event lost against clear");

	property p_core_tick;
		@(posedge clock) disable iff (!rstn)
		(pend == 64'h1 && vector_priority_word[4:2] != 3'h0)
			|=> (irq_req && irq_vector == 6'h00);
	endproperty
	a_core_tick: assert property (p_core_tick)
		else $error("core tick not on vector 0");

	property p_spi1_share;
		@(posedge clock) disable iff (!rstn)
		(pend == 64'h2000000 && vector_priority_word[188:186] != 3'h0)
			|=> irq_vector == 6'h17;
	endproperty
	a_spi1_share: assert property (p_spi1_share)
		else $error("spi1 done not on vector 23");

	property p_uart1_share;
		@(posedge clock) disable iff (!rstn)
		(pend == 64'h10000000 && vector_priority_word[196:194] != 3'h0)
			|=> irq_vector == 6'h18;
	endproperty
	a_uart1_share: assert property (p_uart1_share)
		else $error("uart1 tx not on vector 24");

	property p_usb;
		@(posedge clock) disable iff (!rstn)
		(pend == 64'h0200000000000000 &&
			vector_priority_word[364:362] != 3'h0)
			|=> (irq_req && irq_vector == 6'h2d);
	endproperty
	a_usb: assert property (p_usb)
		else $error("usb not on vector 45");

	property p_dma0;
		@(posedge clock) disable iff (!rstn)
		(pend == 64'h0001000000000000 &&
			vector_priority_word[292:290] != 3'h0)
			|=> irq_vector == 6'h24;
	endproperty
	a_dma0: assert property (p_dma0)
		else $error("dma0 not on vector 36");

	property p_no_pend;
		@(posedge clock) disable iff (!rstn)
		(pend == '0) |=> !irq_req;
	endproperty
	a_no_pend: assert property (p_no_pend)
		else $error("request with nothing pending");

	property p_stall;
		@(posedge clock) disable iff (!rstn)
		(wait_enter && !found) |=> core_stalled;
	endproperty
	a_stall: assert property (p_stall)
		else $error("wait did not stall");

	property p_wake;
		@(posedge clock) disable iff (!rstn)
		(core_stalled && found) |=> (!core_stalled && irq_req);
	endproperty
	a_wake: assert property (p_wake)
		else $error("stall not released by interrupt");
endmodule // irq_vector_map

/* File: verification/source_model.sv */
// peripheral source model: registered one-cycle event pulses
`timescale 1ns/1ps
module source_model (
	input wire logic clock,
	input wire logic [63:0] want,
	output logic [63:0] src_event
);
	always_ff @(posedge clock) begin
		src_event <= want;
	end
endmodule // source_model

/* File: verification/interrupt_source_vector_map_bench.sv */
// self-checking bench for the interrupt vector mapper
`timescale 1ns/1ps
module interrupt_source_vector_map_bench;
	logic clock, rstn, wait_enter, irq_req, core_stalled, en;
	logic [63:0] want, src_event, flag_clear, flag_set, flags;
	logic [31:0] enable_word_low, enable_word_high;
	logic [31:0] flag_word_low, flag_word_high;
	logic [383:0] vector_priority_word;
	logic [5:0] irq_vector, v;
	logic [2:0] irq_level, p;
	logic [7:0] seed;
	int n_mismatch, comparisons, iv;
	logic ok;
	assign flags = {flag_word_high, flag_word_low};
	source_model source_model_inst (.clock(clock), .want(want),
		.src_event(src_event));
	irq_vector_map irq_vector_map_inst (.clock(clock), .rstn(rstn),
		.src_event(src_event), .flag_clear(flag_clear),
		.flag_set(flag_set), .enable_word_low(enable_word_low),
		.enable_word_high(enable_word_high),
		.vector_priority_word(vector_priority_word),
		.wait_enter(wait_enter), .flag_word_low(flag_word_low),
		.flag_word_high(flag_word_high), .irq_req(irq_req),
		.irq_vector(irq_vector), .irq_level(irq_level),
		.core_stalled(core_stalled));
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// expected vector, 6'h3f for unassigned requests
	function automatic logic [5:0] vec_for(input int r);
		if (r < 23) return 6'(r);
		if (r < 26) return 6'h17;
		if (r < 29) return 6'h18;
		if (r < 32) return 6'h19;
		if (r < 37) return 6'(r - 6);
		if (r < 40) return 6'h1f;
		if (r < 43) return 6'h20;
		if (r < 46) return 6'h21;
		if (r < 52) return 6'(r - 12);
		if (r == 56) return 6'h2c;
		if (r == 57) return 6'h2d;
		return 6'h3f;
	endfunction
	task automatic chk(input string what, input logic [63:0] exp, got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic complete_run;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic clr;
		@(posedge clock) flag_clear <= '1;
		@(posedge clock) flag_clear <= '0;
	endtask
	// event reaches flags one edge after the pulse leaves the model
	task automatic fire(input logic [63:0] m);
		@(posedge clock) want <= m;
		@(posedge clock) want <= '0;
		repeat (2) @(posedge clock);
		@(negedge clock);
	endtask
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	initial begin
		repeat (5000) @(posedge clock);
		n_mismatch++;
		complete_run();
	end
	initial begin
		rstn = 1'b0;
		want = '0;
		flag_clear = '0;
		flag_set = '0;
		{enable_word_high, enable_word_low} = '1;
		vector_priority_word = '0;
		wait_enter = 1'b0;
		seed = 8'h36;
		repeat (10) @(posedge clock);
		rstn <= 1'b1;
		for (int r = 0; r < 64; r++) begin
			seed = lfsr(seed);
			p = (seed[2:0] == 3'h0) ? 3'h7 : seed[2:0];
			en = seed[6] | seed[5];
			v = vec_for(r);
			iv = int'(v);
			ok = (v != 6'h3f) && en;
			clr();
			vector_priority_word <= '0;
			if (v != 6'h3f) begin
				vector_priority_word[8*iv+2 +: 3] <= p;
				vector_priority_word[8*iv +: 2] <= seed[4:3];
			end
			{enable_word_high, enable_word_low} <= en ? '1 : ~(64'h1 << r);
			fire(64'h1 << r);
			chk("flag", v != 6'h3f, flags[r]);
			chk("irq_req", ok, irq_req);
			chk("vec", ok ? v : 6'h0, irq_vector);
			chk("vec", ok ? v : 6'h0, irq_vector);
			chk("level", ok ? p : 3'h0, irq_level);
		end
		clr();
		vector_priority_word <= '0;
		{enable_word_high, enable_word_low} <= '1;
		vector_priority_word[8*23+2 +: 3] <= 3'h5;
		vector_priority_word[8*24+2 +: 3] <= 3'h5;
		fire(64'h3 << 25);
		chk("tie vec", 6'h17, irq_vector);
		repeat (20) @(posedge clock);
		@(negedge clock);
		chk("held flags", 64'h3 << 25, flags);
		@(posedge clock) vector_priority_word[8*23+2 +: 3] <= 3'h0;
		repeat (2) @(posedge clock);
		@(negedge clock);
		chk("zero prio vec", 6'h18, irq_vector);
		clr();
		@(posedge clock) want <= 64'h20;
		@(posedge clock) begin
			want <= '0;
			flag_clear <= 64'h20;
			flag_set <= 64'h40;
		end
		@(posedge clock) begin
			flag_clear <= 64'h60;
			flag_set <= '0;
		end
		@(negedge clock);
		chk("event vs clear", 64'h60, flags);
		@(posedge clock) flag_clear <= '0;
		clr();
		@(posedge clock) wait_enter <= 1'b1;
		@(posedge clock) wait_enter <= 1'b0;
		@(negedge clock);
		chk("stalled", 1'b1, core_stalled);
		fire(64'h1 << 26);
		chk("stalled", 1'b0, core_stalled);
		chk("irq_req", 1'b1, irq_req);
		complete_run();
	end
endmodule // interrupt_source_vector_map_bench
